// file: rtl/pcs_core.v
// How it works
// - flag-updating ops override written zero/digit/carry; zero-only ops here still take written digit/carry
// - timeout and powerdown never register-writable
// - subtraction carries are active-low borrows
// - 15-bit counter, low byte read/write
// - any reset clears whole counter
// - low byte write loads holding into high
// - call takes operand plus holding bits 6:3
// - computed call uses wreg and holding
// - wreg branch: counter+1+unsigned wreg
// - relative branch: counter+1+signed operand
// - sixteen fifteen-bit levels, separate storage
// - calls/interrupt push, returns pop, holding kept
// - error reset off: stack wraps circularly
// - overflow/underflow flags set in both modes
// - error reset on: overflow/underflow resets device
// - stack pointer selects exposed top entry
// - push increments then writes; pop reads first
// - pointer marks last pushed entry
// - digit carry from bit 3, carry from msb
// - powerdown cleared by sleep, set by clrwdt
//
// Our own choices: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "pcs_map.vh"

module pcs_core (
    input wire MCLK_I,            // core clock
    input wire RST_I,             // any device reset, sync, high
    input wire POR_I,             // reset is power-up, with RST_I
    input wire [7:0] ADR_I,       // wishbone byte address
    input wire [31:0] DAT_I,      // wishbone write data
    output wire [31:0] DAT_O,     // wishbone read data
    input wire WE_I,              // wishbone write
    input wire [3:0] SEL_I,       // wishbone byte lanes
    input wire CYC_I,             // wishbone cycle
    input wire STB_I,             // wishbone strobe
    output wire ACK_O,            // wishbone acknowledge
    input wire INC_I,             // advance counter by one
    input wire LOW_WR_I,          // instruction writes low byte
    input wire [7:0] LOW_DATA_I,  // low byte value
    input wire HOLD_WR_I,         // instruction writes holding
    input wire [6:0] HOLD_DATA_I, // holding value
    input wire CALL_I,            // direct call
    input wire [10:0] CALL_OP_I,  // call operand
    input wire CCALL_I,           // computed call
    input wire WBR_I,             // branch by wreg
    input wire RBR_I,             // relative branch
    input wire [8:0] REL_OP_I,    // signed branch offset
    input wire RETURN_I,          // any of the three returns
    input wire IRQ_I,             // interrupt vectoring
    input wire [7:0] WREG_I,      // working register
    input wire ARITH_EN_I,        // add or subtract executes
    input wire ARITH_SUB_I,       // subtract a - b
    input wire [7:0] ARITH_A_I,   // first operand
    input wire [7:0] ARITH_B_I,   // second operand
    input wire ZONLY_EN_I,        // logic op updates zero only
    input wire ZONLY_I,           // zero value for logic op
    input wire FLAG_WR_I,         // instruction writes flag reg
    input wire [7:0] FLAG_DATA_I, // flag reg write value
    input wire SLEEP_I,           // sleep executes
    input wire CLRWDT_I,          // watchdog clear executes
    input wire WDT_TO_I,          // watchdog time-out
    output wire [`PCS_PC_W-1:0] PC_O, // program counter
    output wire [7:0] FLAGS_O,    // flag register
    output wire [7:0] ARITH_RES_O, // last arithmetic result
    output wire DEV_RESET_O       // stack error reset request
);
    reg [`PCS_PC_W-1:0] pc_q, pc_d;
    reg [6:0] hold_q;
    reg [4:0] sp_q, sp_d;
    reg z_q, digit_q, c_q, to_q, pwrdn_q;
    reg ovf_q, unf_q, ovf_set, unf_set;
    reg err_rst_q;
    reg rst_req_q, rst_req_d;
    reg ack_q;
    reg [31:0] dat_q;
    reg [7:0] res_q;
    reg mem_we;
    reg [3:0] mem_widx;
    reg [`PCS_PC_W-1:0] mem_wdata;
    wire [`PCS_PC_W-1:0] tos;
    wire [`PCS_PC_W-1:0] pc_inc;
    wire [`PCS_PC_W-1:0] call_tgt, ccall_tgt, wbr_tgt, rbr_tgt;
    wire [4:0] sp_push, sp_pop;
    wire push, pop, bus_req, bus_wr, bus_rd;
    wire [8:0] sum9;
    wire [4:0] sum5;
    wire [7:0] b_eff;
    reg [31:0] rd_val;

    function hit;
        input [7:0] adr;
        input [7:0] off;
        begin
            hit = (adr == off);
        end
    endfunction

    // bus: ack one cycle after request, write lands with ack
    assign bus_req = CYC_I & STB_I;
    assign bus_wr = bus_req & ack_q & WE_I & SEL_I[0];
    assign bus_rd = bus_req & ~ack_q;
    assign ACK_O = ack_q;
    assign DAT_O = dat_q;

    assign pc_inc = pc_q + 15'h0001;
    assign call_tgt = {hold_q[6:3], CALL_OP_I};
    assign ccall_tgt = {hold_q, WREG_I};
    assign wbr_tgt = pc_inc + {7'h00, WREG_I};
    assign rbr_tgt = pc_inc + {{6{REL_OP_I[8]}}, REL_OP_I};

    // five-bit pointer: all ones means empty, so 0 is first level
    assign sp_push = (sp_q == `PCS_SP_FULL) ? 5'h00 : sp_q + 5'h01;
    assign sp_pop = (sp_q == `PCS_SP_EMPTY) ? `PCS_SP_WRAP_POP
                                            : sp_q - 5'h01;
    assign push = IRQ_I | CALL_I | CCALL_I;
    assign pop = RETURN_I;

    pcs_stack_mem u_stack (
        .clk_i(MCLK_I),
        .we_i(mem_we),
        .widx_i(mem_widx),
        .wdata_i(mem_wdata),
        .ridx_i(sp_q[3:0]),
        .rdata_o(tos)
    );

    // core events beat a software access in the same cycle
    always @*
    begin
        pc_d = pc_q;
        sp_d = sp_q;
        mem_we = 1'b0;
        mem_widx = sp_q[3:0];
        mem_wdata = tos;
        ovf_set = 1'b0;
        unf_set = 1'b0;
        rst_req_d = 1'b0;
        if (push)
        begin
            ovf_set = (sp_q == `PCS_SP_FULL);
            if ((sp_q == `PCS_SP_FULL) && err_rst_q)
            begin
                rst_req_d = 1'b1;
            end
            else
            begin
                sp_d = sp_push;
                mem_we = 1'b1;
                mem_widx = sp_push[3:0];
                if (IRQ_I)
                begin
                    mem_wdata = pc_q;
                    pc_d = `PCS_IRQ_VECTOR;
                end
                else if (CALL_I)
                begin
                    mem_wdata = pc_inc;
                    pc_d = call_tgt;
                end
                else
                begin
                    mem_wdata = pc_inc;
                    pc_d = ccall_tgt;
                end
            end
        end
        else if (pop)
        begin
            unf_set = (sp_q == `PCS_SP_EMPTY);
            if ((sp_q == `PCS_SP_EMPTY) && err_rst_q)
            begin
                rst_req_d = 1'b1;
            end
            else
            begin
                pc_d = tos;
                sp_d = sp_pop;
            end
        end
        else if (WBR_I)
        begin
            pc_d = wbr_tgt;
        end
        else if (RBR_I)
        begin
            pc_d = rbr_tgt;
        end
        else if (LOW_WR_I)
        begin
            pc_d = {hold_q, LOW_DATA_I};
        end
        else if (INC_I)
        begin
            pc_d = pc_inc;
        end
        else if (bus_wr)
        begin
            if (hit(ADR_I, `PCS_ADR_COUNTER_LOW))
            begin
                pc_d = {hold_q, DAT_I[7:0]};
            end
            else if (hit(ADR_I, `PCS_ADR_STACK_PTR))
            begin
                sp_d = DAT_I[4:0];
            end
            else if (hit(ADR_I, `PCS_ADR_TOP_LOW))
            begin
                mem_we = 1'b1;
                mem_wdata = {tos[14:8], DAT_I[7:0]};
            end
            else if (hit(ADR_I, `PCS_ADR_TOP_HIGH))
            begin
                mem_we = 1'b1;
                mem_wdata = {DAT_I[6:0], tos[7:0]};
            end
        end
    end

    always @(posedge MCLK_I)
    begin
        if (RST_I)
        begin
            pc_q <= `PCS_RST_PC;
            sp_q <= `PCS_SP_EMPTY;
            rst_req_q <= 1'b0;
        end
        else
        begin
            pc_q <= pc_d;
            sp_q <= sp_d;
            rst_req_q <= rst_req_d;
        end
    end

    // holding register: stack traffic leaves it alone
    always @(posedge MCLK_I)
    begin
        if (RST_I)
        begin
            hold_q <= `PCS_RST_HOLD;
            err_rst_q <= `PCS_RST_ERR_RST;
        end
        else
        begin
            if (HOLD_WR_I)
            begin
                hold_q <= HOLD_DATA_I;
            end
            else if (bus_wr && hit(ADR_I, `PCS_ADR_HIGH_HOLD))
            begin
                hold_q <= DAT_I[6:0];
            end
            if (bus_wr && hit(ADR_I, `PCS_ADR_CONFIG))
            begin
                err_rst_q <= DAT_I[`PCS_BIT_ERR_RST];
            end
        end
    end

    // subtraction adds the complement, so carries read as not-borrow
    assign b_eff = ARITH_SUB_I ? ~ARITH_B_I : ARITH_B_I;
    assign sum9 = {1'b0, ARITH_A_I} + {1'b0, b_eff}
                  + {8'h00, ARITH_SUB_I};
    assign sum5 = {1'b0, ARITH_A_I[3:0]} + {1'b0, b_eff[3:0]}
                  + {4'h0, ARITH_SUB_I};

    always @(posedge MCLK_I)
    begin
        if (RST_I && POR_I)
        begin
            z_q <= 1'b0;
            digit_q <= 1'b0;
            c_q <= 1'b0;
            res_q <= 8'h00;
        end
        else if (!RST_I)
        begin
            if (ARITH_EN_I)
            begin
                res_q <= sum9[7:0];
                z_q <= (sum9[7:0] == 8'h00);
                digit_q <= sum5[4];
                c_q <= sum9[8];
            end
            else if (ZONLY_EN_I)
            begin
                z_q <= ZONLY_I;
                if (FLAG_WR_I)
                begin
                    digit_q <= FLAG_DATA_I[`PCS_BIT_DIGIT];
                    c_q <= FLAG_DATA_I[`PCS_BIT_CARRY];
                end
            end
            else if (FLAG_WR_I)
            begin
                z_q <= FLAG_DATA_I[`PCS_BIT_ZERO];
                digit_q <= FLAG_DATA_I[`PCS_BIT_DIGIT];
                c_q <= FLAG_DATA_I[`PCS_BIT_CARRY];
            end
            else if (bus_wr && hit(ADR_I, `PCS_ADR_FLAGS))
            begin
                z_q <= DAT_I[`PCS_BIT_ZERO];
                digit_q <= DAT_I[`PCS_BIT_DIGIT];
                c_q <= DAT_I[`PCS_BIT_CARRY];
            end
        end
    end

    // timeout/powerdown only move on their events; warm resets keep them
    always @(posedge MCLK_I)
    begin
        if (RST_I && POR_I)
        begin
            to_q <= 1'b1;
            pwrdn_q <= 1'b1;
        end
        else if (!RST_I)
        begin
            if (WDT_TO_I)
            begin
                to_q <= 1'b0;
            end
            else if (SLEEP_I || CLRWDT_I)
            begin
                to_q <= 1'b1;
            end
            if (SLEEP_I)
            begin
                pwrdn_q <= 1'b0;
            end
            else if (CLRWDT_I)
            begin
                pwrdn_q <= 1'b1;
            end
        end
    end

    // stack flags must outlive the reset they trigger; set beats clear
    always @(posedge MCLK_I)
    begin
        if (RST_I && POR_I)
        begin
            ovf_q <= 1'b0;
            unf_q <= 1'b0;
        end
        else if (!RST_I)
        begin
            if (ovf_set)
            begin
                ovf_q <= 1'b1;
            end
            else if (bus_wr && hit(ADR_I, `PCS_ADR_STACK_ERR)
                     && DAT_I[`PCS_BIT_OVF])
            begin
                ovf_q <= 1'b0;
            end
            if (unf_set)
            begin
                unf_q <= 1'b1;
            end
            else if (bus_wr && hit(ADR_I, `PCS_ADR_STACK_ERR)
                     && DAT_I[`PCS_BIT_UNF])
            begin
                unf_q <= 1'b0;
            end
        end
    end

    always @*
    begin
        rd_val = 32'h00000000;
        if (hit(ADR_I, `PCS_ADR_COUNTER_LOW))
        begin
            rd_val[7:0] = pc_q[7:0];
        end
        else if (hit(ADR_I, `PCS_ADR_HIGH_HOLD))
        begin
            rd_val[6:0] = hold_q;
        end
        else if (hit(ADR_I, `PCS_ADR_FLAGS))
        begin
            rd_val[7:0] = FLAGS_O;
        end
        else if (hit(ADR_I, `PCS_ADR_STACK_PTR))
        begin
            rd_val[4:0] = sp_q;
        end
        else if (hit(ADR_I, `PCS_ADR_TOP_LOW))
        begin
            rd_val[7:0] = tos[7:0];
        end
        else if (hit(ADR_I, `PCS_ADR_TOP_HIGH))
        begin
            rd_val[6:0] = tos[14:8];
        end
        else if (hit(ADR_I, `PCS_ADR_CONFIG))
        begin
            rd_val[`PCS_BIT_ERR_RST] = err_rst_q;
        end
        else if (hit(ADR_I, `PCS_ADR_STACK_ERR))
        begin
            rd_val[`PCS_BIT_OVF] = ovf_q;
            rd_val[`PCS_BIT_UNF] = unf_q;
        end
    end

    always @(posedge MCLK_I)
    begin
        if (RST_I)
        begin
            ack_q <= 1'b0;
            dat_q <= 32'h00000000;
        end
        else
        begin
            ack_q <= bus_req & ~ack_q;
            if (bus_rd)
            begin
                dat_q <= rd_val;
            end
        end
    end

    assign FLAGS_O = {3'b000, to_q, pwrdn_q, z_q, digit_q, c_q};
    assign PC_O = pc_q;
    assign ARITH_RES_O = res_q;
    assign DEV_RESET_O = rst_req_q;
endmodule
`default_nettype wire

// file: include/pcs_map.vh
`ifndef PCS_MAP_VH
`define PCS_MAP_VH

// register byte addresses on the bus
`define PCS_ADR_COUNTER_LOW 8'h00
`define PCS_ADR_HIGH_HOLD 8'h04
`define PCS_ADR_FLAGS 8'h08
`define PCS_ADR_STACK_PTR 8'h0C
`define PCS_ADR_TOP_LOW 8'h10
`define PCS_ADR_TOP_HIGH 8'h14
`define PCS_ADR_CONFIG 8'h18
`define PCS_ADR_STACK_ERR 8'h1C

// flag register bit positions
`define PCS_BIT_CARRY 0
`define PCS_BIT_DIGIT 1
`define PCS_BIT_ZERO 2
`define PCS_BIT_POWERDOWN 3
`define PCS_BIT_TIMEOUT 4

// stack error register and config bit positions
`define PCS_BIT_OVF 7
`define PCS_BIT_UNF 6
`define PCS_BIT_ERR_RST 0

// stack geometry and pointer codes
`define PCS_STACK_DEPTH 16
`define PCS_PC_W 15
`define PCS_SP_EMPTY 5'h1F
`define PCS_SP_FULL 5'h0F
`define PCS_SP_WRAP_POP 5'h0E

// reset values and interrupt vector
`define PCS_RST_PC 15'h0000
`define PCS_RST_HOLD 7'h00
`define PCS_RST_ERR_RST 1'b0
`define PCS_IRQ_VECTOR 15'h0004

`endif

// file: rtl/pcs_stack_mem.v
`timescale 1ns/1ps
`default_nettype none
`include "pcs_map.vh"

module pcs_stack_mem (
    input wire clk_i,                   // core clock
    input wire we_i,                    // write strobe
    input wire [3:0] widx_i,            // write level
    input wire [`PCS_PC_W-1:0] wdata_i, // write value
    input wire [3:0] ridx_i,            // read level
    output wire [`PCS_PC_W-1:0] rdata_o // read value
);
    wire [`PCS_PC_W-1:0] lvl [0:`PCS_STACK_DEPTH-1];
    wire [`PCS_STACK_DEPTH-1:0] wsel;

    // one-hot level select keeps the loop index out of the compare
    assign wsel = 16'h0001 << widx_i;

    // levels are not reset: contents are undefined until pushed
    genvar g;
    generate
        for (g = 0; g < `PCS_STACK_DEPTH; g = g + 1)
        begin : g_lvl
            reg [`PCS_PC_W-1:0] ent_q;
            always @(posedge clk_i)
            begin
                if (we_i && wsel[g])
                begin
                    ent_q <= wdata_i;
                end
            end
            assign lvl[g] = ent_q;
        end
    endgenerate

    assign rdata_o = lvl[ridx_i];
endmodule
`default_nettype wire

// file: sim/pcs_core_sva.sv
`timescale 1ns/1ps
`default_nettype none
module pcs_core_chk (
    input wire MCLK_I,
    input wire RST_I,
    input wire CYC_I,
    input wire STB_I,
    input wire ACK_O,
    input wire DEV_RESET_O,
    input wire [14:0] PC_O,
    input wire IRQ_I,
    input wire CALL_I,
    input wire CCALL_I,
    input wire RETURN_I,
    input wire WBR_I,
    input wire RBR_I,
    input wire [8:0] REL_OP_I,
    input wire [7:0] WREG_I,
    input wire ARITH_EN_I,
    input wire ARITH_SUB_I,
    input wire [7:0] ARITH_A_I,
    input wire [7:0] ARITH_B_I,
    input wire [7:0] ARITH_RES_O,
    input wire [7:0] FLAGS_O,
    input wire FLAG_WR_I,
    input wire SLEEP_I,
    input wire CLRWDT_I,
    input wire WDT_TO_I
);
    default clocking @(posedge MCLK_I);
    endclocking
    default disable iff (RST_I);
    wire push = IRQ_I | CALL_I | CCALL_I | RETURN_I;
    wire [14:0] rel_ext = {{6{REL_OP_I[8]}}, REL_OP_I};
    wire [1:0] tp = FLAGS_O[4:3];
    // subtract is add of the complement plus one
    wire [7:0] opb = ARITH_SUB_I ? ~ARITH_B_I : ARITH_B_I;
    wire [8:0] sum9 = {1'b0, ARITH_A_I} + {1'b0, opb} + {8'h00, ARITH_SUB_I};
    wire [4:0] lo5 = {1'b0, ARITH_A_I[3:0]} + {1'b0, opb[3:0]}
        + {4'h0, ARITH_SUB_I};
    wire [9:0] alu = {lo5[4], sum9};
    sequence bus_take;
        CYC_I && STB_I && !ACK_O;
    endsequence
    sequence ack_once;
        ACK_O ##1 !ACK_O;
    endsequence
    bus_ack_a: assert property (bus_take |=> ack_once)
        else $error("ack not a single pulse after request");
    reset_pc_a: assert property (
        disable iff (1'b0) RST_I |=> PC_O == 15'h0000)
        else $error("counter not cleared by reset");
    wreg_branch_a: assert property (
        WBR_I && !push |=> PC_O == $past(PC_O) + 15'h0001
        + {7'h00, $past(WREG_I)}) else $error("wreg branch target wrong");
    rel_branch_a: assert property (
        RBR_I && !push && !WBR_I |=> PC_O == $past(PC_O) + 15'h0001
        + $past(rel_ext)) else $error("relative branch target wrong");
    irq_vec_a: assert property (
        IRQ_I |=> (PC_O == 15'h0004) or (##[0:1] DEV_RESET_O))
        else $error("interrupt did not vector");
    arith_add_a: assert property (
        ARITH_EN_I && !ARITH_SUB_I |=> {FLAGS_O[1:0], ARITH_RES_O}
        == $past(alu) && FLAGS_O[2] == (ARITH_RES_O == 8'h00))
        else $error("add flags wrong");
    arith_sub_a: assert property (
        ARITH_EN_I && ARITH_SUB_I |=> {FLAGS_O[1:0], ARITH_RES_O}
        == $past(alu)) else $error("subtract borrow flags wrong");
    flag_keep_a: assert property (
        FLAG_WR_I && !(SLEEP_I | CLRWDT_I | WDT_TO_I) |=> $stable(tp))
        else $error("timeout or powerdown written");
    sleep_pd_a: assert property (
        SLEEP_I && !WDT_TO_I && !CLRWDT_I |=> tp == 2'b10)
        else $error("sleep did not clear powerdown");
    dev_pulse_a: assert property (
        DEV_RESET_O |=> !DEV_RESET_O) else $error("reset request too long");
endmodule
bind pcs_core pcs_core_chk u_chk (
    .MCLK_I(MCLK_I), .RST_I(RST_I), .CYC_I(CYC_I), .STB_I(STB_I),
    .ACK_O(ACK_O), .DEV_RESET_O(DEV_RESET_O), .PC_O(PC_O), .IRQ_I(IRQ_I),
    .CALL_I(CALL_I), .CCALL_I(CCALL_I), .RETURN_I(RETURN_I),
    .WBR_I(WBR_I), .RBR_I(RBR_I), .REL_OP_I(REL_OP_I), .WREG_I(WREG_I),
    .ARITH_EN_I(ARITH_EN_I), .ARITH_SUB_I(ARITH_SUB_I),
    .ARITH_A_I(ARITH_A_I), .ARITH_B_I(ARITH_B_I),
    .ARITH_RES_O(ARITH_RES_O), .FLAGS_O(FLAGS_O), .FLAG_WR_I(FLAG_WR_I),
    .SLEEP_I(SLEEP_I), .CLRWDT_I(CLRWDT_I), .WDT_TO_I(WDT_TO_I)
);
`default_nettype wire

// file: sim/pcs_exec_model.sv
`timescale 1ns/1ps
`default_nettype none
module pcs_exec_model (
    input wire logic clk_i,        // core clock
    input wire logic rst_i,        // reset
    input wire logic [15:0] req_i, // requested events
    output logic [15:0] ev_o       // event pulses, one cycle late
);
    // issued from a flop so each pulse comes one cycle late and lasts as long as its request
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ev_o <= 16'h0000;
        else
            ev_o <= req_i;
    end
endmodule
`default_nettype wire

// file: sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk, rst, por, cyc, stb, we;
    logic [3:0] sel;
    logic [7:0] adr, wv, rdv;
    logic [31:0] dwr;
    logic [15:0] req;
    logic [10:0] arg;
    int err_total, cmp_count;
    wire [15:0] ev;
    wire [31:0] dat;
    wire [14:0] pc;
    wire [7:0] flags, res;
    wire ack, drst;
    // event bits: inc lowwr holdwr call ccall wbr rbr ret irq add sub
    // zonly flagwr sleep clrwdt wdt, from bit 0 up
    pcs_exec_model u_exec (.clk_i(clk), .rst_i(rst), .req_i(req), .ev_o(ev));
    pcs_core dut (
        .MCLK_I(clk), .RST_I(rst), .POR_I(por), .ADR_I(adr), .DAT_I(dwr),
        .DAT_O(dat), .WE_I(we), .SEL_I(sel), .CYC_I(cyc), .STB_I(stb),
        .ACK_O(ack), .INC_I(ev[0]), .LOW_WR_I(ev[1]),
        .LOW_DATA_I(arg[7:0]), .HOLD_WR_I(ev[2]), .HOLD_DATA_I(arg[6:0]),
        .CALL_I(ev[3]), .CALL_OP_I(arg), .CCALL_I(ev[4]), .WBR_I(ev[5]),
        .RBR_I(ev[6]), .REL_OP_I(arg[8:0]), .RETURN_I(ev[7]),
        .IRQ_I(ev[8]), .WREG_I(wv), .ARITH_EN_I(ev[9]),
        .ARITH_SUB_I(ev[10]), .ARITH_A_I(arg[7:0]), .ARITH_B_I(wv),
        .ZONLY_EN_I(ev[11]), .ZONLY_I(arg[0]), .FLAG_WR_I(ev[12]),
        .FLAG_DATA_I(arg[7:0]), .SLEEP_I(ev[13]), .CLRWDT_I(ev[14]),
        .WDT_TO_I(ev[15]), .PC_O(pc), .FLAGS_O(flags),
        .ARITH_RES_O(res), .DEV_RESET_O(drst)
    );
    task test_done;
    begin
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    end
    endtask
    task chk(input logic [15:0] got, input logic [15:0] exp);
    begin
        cmp_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    end
    endtask
    task wb(input logic w, input logic [7:0] a, input logic [7:0] d,
        input logic [3:0] s);
    begin
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dwr <= {24'h000000, d};
        sel <= s;
        // no local limit: only the watchdog may end this wait
        do @(posedge clk); while (ack !== 1'b1);
        rdv = dat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        wb(1'b1, a, d, 4'h1);
    endtask
    task rdc(input logic [7:0] a, input logic [7:0] e);
    begin
        wb(1'b0, a, 8'h00, 4'h1);
        chk({8'h00, rdv}, {8'h00, e});
    end
    endtask
    task ev_go(input logic [15:0] m, input logic [10:0] a,
        input logic [7:0] w);
    begin
        @(posedge clk);
        req <= m;
        arg <= a;
        wv <= w;
        @(posedge clk);
        req <= 16'h0000;
        @(posedge clk);
        #1;
    end
    endtask
    task do_reset(input logic p);
    begin
        @(posedge clk);
        rst <= 1'b1;
        por <= p;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        por <= 1'b0;
    end
    endtask
    task t_reset;
    begin
        #1;
        chk({1'b0, pc}, 16'h0000);
        chk({8'h00, flags}, 16'h0018);
        rdc(8'h0C, 8'h1F);
        rdc(8'h1C, 8'h00);
        wr(8'h40, 8'h5A);
        rdc(8'h40, 8'h00);
    end
    endtask
    task t_load;
    begin
        ev_go(16'h0004, 11'h055, 8'h00);
        rdc(8'h04, 8'h55);
        ev_go(16'h0002, 11'h0A3, 8'h00);
        chk({1'b0, pc}, 16'h55A3);
        rdc(8'h00, 8'hA3);
        ev_go(16'h0001, 11'h000, 8'h00);
        wb(1'b1, 8'h04, 8'h11, 4'h0);
        rdc(8'h04, 8'h55);
        wr(8'h04, 8'h12);
        wr(8'h00, 8'h34);
        #1 chk({1'b0, pc}, 16'h1234);
        wr(8'h04, 8'h55);
        wr(8'h00, 8'hA4);
        #1 chk({1'b0, pc}, 16'h55A4);
    end
    endtask
    task t_calls;
    begin
        ev_go(16'h0008, 11'h123, 8'h00);
        chk({1'b0, pc}, 16'h5123);
        rdc(8'h0C, 8'h00);
        rdc(8'h10, 8'hA5);
        ev_go(16'h0010, 11'h000, 8'h3C);
        chk({1'b0, pc}, 16'h553C);
        ev_go(16'h0100, 11'h000, 8'h00);
        chk({1'b0, pc}, 16'h0004);
        rdc(8'h0C, 8'h02);
        rdc(8'h04, 8'h55);
        wr(8'h0C, 8'h00);
        rdc(8'h14, 8'h55);
        wr(8'h0C, 8'h02);
        wr(8'h10, 8'h40);
    end
    endtask
    task t_returns;
    begin
        ev_go(16'h0080, 11'h000, 8'h00);
        chk({1'b0, pc}, 16'h5540);
        ev_go(16'h0080, 11'h000, 8'h00);
        chk({1'b0, pc}, 16'h5124);
        ev_go(16'h0080, 11'h000, 8'h00);
        chk({1'b0, pc}, 16'h55A5);
        rdc(8'h0C, 8'h1F);
    end
    endtask
    task t_branch;
    begin
        ev_go(16'h0020, 11'h000, 8'hFF);
        chk({1'b0, pc}, 16'h56A5);
        ev_go(16'h0040, 11'h100, 8'h00);
        chk({1'b0, pc}, 16'h55A6);
        ev_go(16'h0040, 11'h05A, 8'h00);
        chk({1'b0, pc}, 16'h5601);
    end
    endtask
    task t_wrap;
    begin
        for (int i = 0; i < 17; i++)
            ev_go(16'h0008, 11'(i), 8'h00);
        rdc(8'h0C, 8'h00);
        rdc(8'h10, 8'h10);
        wr(8'h14, 8'h2A);
        rdc(8'h14, 8'h2A);
        rdc(8'h10, 8'h10);
        rdc(8'h1C, 8'h80);
        wr(8'h1C, 8'hC0);
        rdc(8'h1C, 8'h00);
    end
    endtask
    task t_stverr;
    begin
        wr(8'h18, 8'h01);
        wr(8'h0C, 8'h0F);
        ev_go(16'h0008, 11'h7FF, 8'h00);
        chk({1'b0, pc}, 16'h5010);
        for (int n = 0; n < 3 && drst !== 1'b1; n++)
            @(posedge clk) #1;
        chk({15'h0000, drst}, 16'h0001);
        rdc(8'h1C, 8'h80);
        do_reset(1'b0);
        #1;
        chk({1'b0, pc}, 16'h0000);
        rdc(8'h0C, 8'h1F);
        ev_go(16'h0080, 11'h000, 8'h00);
        rdc(8'h1C, 8'hC0);
        rdc(8'h0C, 8'h0E);
    end
    endtask
    task t_flags;
    begin
        wr(8'h08, 8'hFF);
        rdc(8'h08, 8'h1F);
        ev_go(16'h0200, 11'h00F, 8'h01);
        chk({8'h00, flags}, 16'h001A);
        chk({8'h00, res}, 16'h0010);
        ev_go(16'h0200, 11'h0FF, 8'h01);
        chk({8'h00, flags}, 16'h001F);
        ev_go(16'h0600, 11'h005, 8'h06);
        chk({8'h00, flags}, 16'h0018);
        ev_go(16'h0600, 11'h010, 8'h01);
        chk({8'h00, flags}, 16'h0019);
        ev_go(16'h1200, 11'h001, 8'h01);
        chk({8'h00, flags}, 16'h0018);
        ev_go(16'h1800, 11'h006, 8'h00);
        chk({8'h00, flags}, 16'h001A);
    end
    endtask
    task t_power;
    begin
        ev_go(16'h2000, 11'h000, 8'h00);
        chk({14'h0000, flags[4:3]}, 16'h0002);
        ev_go(16'h8000, 11'h000, 8'h00);
        chk({14'h0000, flags[4:3]}, 16'h0000);
        ev_go(16'h4000, 11'h000, 8'h00);
        chk({14'h0000, flags[4:3]}, 16'h0003);
    end
    endtask
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial
    begin
        #40000;
        err_total++;
        test_done;
    end
    initial
    begin
        {rst, por, cyc, stb, we} = 5'h18;
        sel = 4'h1;
        adr = 8'h00;
        wv = 8'h00;
        dwr = 32'h00000000;
        req = 16'h0000;
        arg = 11'h000;
        err_total = 0;
        cmp_count = 0;
        do_reset(1'b1);
        t_reset;
        t_load;
        t_calls;
        t_returns;
        t_branch;
        t_wrap;
        t_stverr;
        t_flags;
        t_power;
        test_done;
    end
endmodule
`default_nettype wire
